// >>> adc_ctl_pkg.sv
package adc_ctl_pkg;
	// converter result
	localparam int          RESULT_W        = 10;           // result width
	localparam logic [9:0]  FULL_SCALE      = 10'h3FF;      // saturated top code
	localparam logic [9:0]  SIGN_FLIP       = 10'h200;      // msb flip for two's complement
	localparam logic [9:0]  RESULT_RST      = 10'h000;      // result after reset

	// conversion timing in conversion clock cycles
	localparam logic [6:0]  SAMPLE_CYC_0    = 7'h04;        // 4 cycles
	localparam logic [6:0]  SAMPLE_CYC_1    = 7'h08;        // 8 cycles
	localparam logic [6:0]  SAMPLE_CYC_2    = 7'h10;        // 16 cycles
	localparam logic [6:0]  SAMPLE_CYC_3    = 7'h40;        // 64 cycles
	localparam logic [6:0]  CONVERT_CYC     = 7'h0B;        // 11 cycles of conversion

	// reference settling
	localparam int          CLK_PERIOD_PS   = 25000;        // 40 MHz
	localparam int          REF_SETTLE_US   = 30;           // longest settle time
	localparam int          REF_SETTLE_CYC  = (REF_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1)
	                                          / CLK_PERIOD_PS;
	localparam int          STALL_LIMIT_DEF = 1024;         // ref_clk cycles without a tick

	// input multiplexer
	localparam int          EXT_CHANNELS    = 8;            // external inputs
	localparam int          INT_CHANNELS    = 4;            // internal sources
	localparam int          NUM_CHANNELS    = EXT_CHANNELS + INT_CHANNELS;

	// reset values of configuration
	localparam logic [1:0]  CLK_SRC_RST     = 2'h0;         // subsystem clock
	localparam logic [2:0]  CLK_DIV_RST     = 3'h0;         // divide by one
	localparam logic [1:0]  SHT_RST         = 2'h0;         // 4 cycles
	localparam logic [3:0]  CHANNEL_RST     = 4'h0;         // channel 0

	// conversion clock sources
	typedef enum logic [1:0] {
		SRC_SUBSYSTEM = 2'b00,
		SRC_MAIN      = 2'b01,
		SRC_AUX       = 2'b10,
		SRC_OSC       = 2'b11
	} clk_src_t;

	// conversion sequencer states
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SYNC    = 2'b01,
		ST_SAMPLE  = 2'b10,
		ST_CONVERT = 2'b11
	} conv_state_t;
endpackage

// >>> conv_clk_divider.sv
`timescale 1ns/1ps
module conv_clk_divider (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic [3:0]             sourceTick,      // one pulse per source clock edge
	input  wire adc_ctl_pkg::clk_src_t  clkSourceSelect, // chosen source
	input  wire logic [2:0]             clkDivideSelect, // ratio minus one
	input  wire logic                   run,             // divider counts while high
	output logic                        convTick         // one pulse per conversion clock
);
	import adc_ctl_pkg::*;

	logic [2:0] divCount;   // source edges seen since last tick
	logic       srcEdge;    // edge of the chosen source

	// pick one source out of four
	always_comb begin
		case (clkSourceSelect)
			SRC_SUBSYSTEM: srcEdge = sourceTick[0];
			SRC_MAIN:      srcEdge = sourceTick[1];
			SRC_AUX:       srcEdge = sourceTick[2];
			SRC_OSC:       srcEdge = sourceTick[3];
			default:       srcEdge = 1'b0;
		endcase
	end

	// divide by field value plus one, restarting while stopped
	always_ff @(posedge ref_clk) begin
		if (rst || !run) begin
			divCount <= 3'h0;
			convTick <= 1'b0;
		end else if (srcEdge && divCount == clkDivideSelect) begin // R25
			divCount <= 3'h0;
			convTick <= 1'b1; // R7
		end else begin
			divCount <= srcEdge ? divCount + 3'h1 : divCount;
			convTick <= 1'b0;
		end
	end
endmodule // conv_clk_divider

// >>> adc_control_ref_power.sv
// Overview of operation
// R1 - result saturates at full scale or zero
// R2 - result straight binary or two's complement
// R3 - core enabled only with core power-on set
// R4 - control writes ignored while gate set
// R5 - no conversion unless gate set
// R6 - one conversion clock times sampling and steps
// R7 - four clock sources, divided one to eight
// R8 - stopped clock aborts conversion, result invalid
// R9 - mux selects one of twelve channels
// R10 - break-before-make channel switching
// R11 - unselected channels isolated, node grounded
// R12 - analog enable disables pin buffers
// R13 - reference-on enables band-gap and buffer
// R14 - level select picks 2.5 V or 1.5 V
// R15 - both select bits buffer external reference
// R16 - software waits up to 30 us settling
// R17 - buffer off when idle, band-gap stays on; the code keeps the buffer on while idle when driving the pin with burst clear
// R18 - burst bit limits buffer to active periods
// R19 - slow-rate bit sets reduced-power buffer
// R20 - core powered down when no conversion active
// R21 - internal oscillator runs only when needed
// R22 - sample period 4, 8, 16 or 64 cycles
// R23 - conversion takes 11 conversion clock cycles
// R24 - activity flag drives all automatic power-down
// R25 - divide field three bits, ratio value plus one
`timescale 1ns/1ps
module adc_control_ref_power #(
	parameter int STALL_LIMIT = adc_ctl_pkg::STALL_LIMIT_DEF  // cycles before a stalled clock aborts
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	// control inputs
	input  wire logic                   cfgWrite,
	input  wire logic                   convEnableGate,
	input  wire logic                   startConv,
	input  wire logic                   corePowerOn,
	input  wire adc_ctl_pkg::clk_src_t  clkSourceSelect,
	input  wire logic [2:0]             clkDivideSelect,
	input  wire logic [1:0]             sampleHoldTimeSelect,
	input  wire logic [3:0]             channelSelect,
	input  wire logic                   twosComplement,
	input  wire logic                   refGeneratorOn,
	input  wire logic                   refLevelSelect,
	input  wire logic                   refPinOutput,
	input  wire logic                   refSelectBit0,
	input  wire logic                   refSelectBit1,
	input  wire logic                   refBufferBurst,
	input  wire logic                   refBufferSlowRate,
	input  wire logic [7:0]             analogPinEnable,
	// clock sources, one pulse per edge
	input  wire logic                   subsystemTick,
	input  wire logic                   mainTick,
	input  wire logic                   auxTick,
	input  wire logic                   oscTick,
	// analog core
	input  wire logic                   compHigh,
	output logic [9:0]                  dacCode,
	output logic                        coreEnable,
	output logic                        sampleActive,
	output logic                        oscEnable,
	output logic [11:0]                 muxConnect,
	output logic [11:0]                 muxGroundNode,
	output logic [7:0]                  pinInputDisable,
	output logic [7:0]                  pinOutputDisable,
	// reference generator
	output logic                        bandgapEnable,
	output logic                        refBufferEnable,
	output logic                        refLevel2v5,
	output logic                        refBufferExternal,
	output logic                        refBufferLowPower,
	output logic                        refDriveOut,
	output logic                        refReady,
	// status
	output logic [9:0]                  conversionResult,
	output logic                        resultValid,
	output logic                        resultInvalid,
	output logic                        busy
);
	import adc_ctl_pkg::*;

	// locked configuration
	logic        cfgCorePower;       // core power-on
	clk_src_t    cfgClkSource;       // clock source
	logic [2:0]  cfgClkDivide;       // clock divide
	logic [1:0]  cfgSampleHold;      // sample length code
	logic [3:0]  cfgChannel;         // selected channel
	logic        cfgTwos;            // result format
	logic        cfgRefOn;           // reference on
	logic        cfgRefLevel;        // 2.5 V when set
	logic        cfgRefOut;          // reference on pin
	logic [1:0]  cfgRefSelect;       // reference select pair
	logic        cfgBurst;           // burst buffer
	logic        cfgSlowRate;        // low-power buffer

	// sequencer
	conv_state_t state;              // sequencer state
	logic [6:0]  tickCount;          // conversion clock cycles in this phase
	logic [9:0]  sarReg;             // successive approximation register
	logic [9:0]  bitMask;            // bit under trial
	logic        convTick;           // conversion clock pulse
	logic        active;             // conversion activity
	logic [15:0] stallCount;         // ref_clk cycles since last tick
	logic [11:0] wantConnect;        // channel the mux should close
	logic [15:0] settleCount;        // reference settle timer

	// sample length from the hold-time code
	function automatic logic [6:0] sampleCycles(input logic [1:0] sel);
		case (sel)
			2'h0:    sampleCycles = SAMPLE_CYC_0;
			2'h1:    sampleCycles = SAMPLE_CYC_1;
			2'h2:    sampleCycles = SAMPLE_CYC_2;
			default: sampleCycles = SAMPLE_CYC_3;
		endcase
	endfunction

	// one-hot code of a channel, empty for codes past the last channel
	function automatic logic [11:0] channelOneHot(input logic [3:0] chan);
		logic [11:0] code;
		code = 12'h000;
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			if (chan == 4'(i)) begin
				code[i] = 1'b1;
			end
		end
		channelOneHot = code;
	endfunction

	// configuration is loaded only while the gate is clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfgCorePower <= 1'b0;
			cfgClkSource <= clk_src_t'(CLK_SRC_RST);
			cfgClkDivide <= CLK_DIV_RST;
			cfgSampleHold <= SHT_RST;
			cfgChannel <= CHANNEL_RST;
			cfgTwos <= 1'b0;
			cfgRefOn <= 1'b0;
			cfgRefLevel <= 1'b0;
			cfgRefOut <= 1'b0;
			cfgRefSelect <= 2'h0;
			cfgBurst <= 1'b0;
			cfgSlowRate <= 1'b0;
		end else if (cfgWrite && !convEnableGate) begin // R4
			cfgCorePower <= corePowerOn;
			cfgClkSource <= clkSourceSelect;
			cfgClkDivide <= clkDivideSelect;
			cfgSampleHold <= sampleHoldTimeSelect;
			cfgChannel <= channelSelect;
			cfgTwos <= twosComplement;
			cfgRefOn <= refGeneratorOn;
			cfgRefLevel <= refLevelSelect;
			cfgRefOut <= refPinOutput;
			cfgRefSelect <= {refSelectBit1, refSelectBit0};
			cfgBurst <= refBufferBurst;
			cfgSlowRate <= refBufferSlowRate;
		end
	end

	// activity spans the wait for sync through the end of conversion
	assign active = (state != ST_IDLE); // R24

	// conversion clock generation
	conv_clk_divider divider (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.sourceTick      ({oscTick, auxTick, mainTick, subsystemTick}),
		.clkSourceSelect (cfgClkSource),
		.clkDivideSelect (cfgClkDivide),
		.run             (active),
		.convTick        (convTick)
	);

	// trial code offered to the comparator
	assign dacCode = sarReg | bitMask;

	// sample, then convert, all counted on the conversion clock
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= ST_IDLE;
			tickCount <= 7'h00;
			sarReg <= RESULT_RST;
			bitMask <= RESULT_RST;
		end else begin
			case (state)
				ST_IDLE: begin
					tickCount <= 7'h00;
					if (startConv && convEnableGate && cfgCorePower) begin // R5 R3
						state <= ST_SYNC;
					end
				end
				ST_SYNC: begin
					// first conversion clock edge starts sampling
					if (convTick) begin // R6
						state <= ST_SAMPLE;
						tickCount <= 7'h01;
					end
				end
				ST_SAMPLE: begin
					if (convTick) begin
						if (tickCount == sampleCycles(cfgSampleHold)) begin // R22
							state <= ST_CONVERT;
							tickCount <= 7'h01;
							sarReg <= RESULT_RST;
							bitMask <= SIGN_FLIP;
						end else begin
							tickCount <= tickCount + 7'h01;
						end
					end
				end
				ST_CONVERT: begin
					if (convTick) begin // R6
						// keep the trial bit while the input is at or above it
						if (bitMask != RESULT_RST && compHigh) begin // R1
							sarReg <= dacCode;
						end
						bitMask <= bitMask >> 1;
						tickCount <= tickCount + 7'h01;
						if (tickCount == CONVERT_CYC) begin // R23
							state <= ST_IDLE;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
			// a stalled conversion clock abandons the conversion
			if (state != ST_IDLE && stallCount == 16'(STALL_LIMIT)) begin // R8
				state <= ST_IDLE;
			end
		end
	end

	// watchdog on the conversion clock
	always_ff @(posedge ref_clk) begin
		if (rst || state == ST_IDLE || convTick) begin
			stallCount <= 16'h0000;
		end else if (stallCount != 16'(STALL_LIMIT)) begin
			stallCount <= stallCount + 16'h0001;
		end
	end

	// result register and its format
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			conversionResult <= RESULT_RST;
			resultValid <= 1'b0;
		end else if (state == ST_CONVERT && convTick && tickCount == CONVERT_CYC) begin
			// full scale stays FULL_SCALE in straight binary
			conversionResult <= cfgTwos ? (sarReg ^ SIGN_FLIP) : sarReg; // R2 R1
			resultValid <= 1'b1;
		end else begin
			resultValid <= 1'b0;
		end
	end

	// invalid flag, set by an abort, cleared by the next start; set wins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			resultInvalid <= 1'b0;
		end else if (state != ST_IDLE && stallCount == 16'(STALL_LIMIT)) begin // R8
			resultInvalid <= 1'b1;
		end else if (state == ST_IDLE && startConv && convEnableGate && cfgCorePower) begin
			resultInvalid <= 1'b0;
		end
	end

	// what the mux should close: selected channel during sampling only
	assign wantConnect = (state == ST_SAMPLE) ? channelOneHot(cfgChannel) : 12'h000; // R9

	// open everything for a cycle before closing a different switch
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			muxConnect <= 12'h000;
		end else if (muxConnect != 12'h000 && muxConnect != wantConnect) begin
			muxConnect <= 12'h000; // R10
		end else begin
			muxConnect <= wantConnect;
		end
	end

	// every open switch grounds its middle node
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			muxGroundNode <= 12'hFFF;
		end else if (muxConnect != 12'h000 && muxConnect != wantConnect) begin
			muxGroundNode <= 12'hFFF; // R11
		end else begin
			muxGroundNode <= ~wantConnect; // R11
		end
	end

	// port pin buffers follow the analog enable bits
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pinInputDisable <= 8'h00;
			pinOutputDisable <= 8'h00;
		end else begin
			pinInputDisable <= analogPinEnable; // R12
			pinOutputDisable <= analogPinEnable; // R12
		end
	end

	// core power and oscillator follow activity
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			coreEnable <= 1'b0;
			oscEnable <= 1'b0;
			sampleActive <= 1'b0;
			busy <= 1'b0;
		end else begin
			coreEnable <= cfgCorePower && active; // R3 R20
			oscEnable <= active && cfgClkSource == SRC_OSC; // R21
			sampleActive <= (state == ST_SAMPLE);
			busy <= active;
		end
	end

	// reference generator enables
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bandgapEnable <= 1'b0;
			refBufferEnable <= 1'b0;
			refLevel2v5 <= 1'b0;
			refBufferExternal <= 1'b0;
			refBufferLowPower <= 1'b0;
			refDriveOut <= 1'b0;
		end else begin
			bandgapEnable <= cfgRefOn; // R13 R17
			// buffer runs while converting, or always when driving the pin unburst
			refBufferEnable <= (cfgRefOn || cfgRefSelect == 2'h3)
			                   && (active || (cfgRefOut && !cfgBurst)); // R13 R17 R18
			refLevel2v5 <= cfgRefLevel; // R14
			refBufferExternal <= (cfgRefSelect == 2'h3); // R15
			refBufferLowPower <= cfgSlowRate; // R19
			refDriveOut <= cfgRefOn && cfgRefOut;
		end
	end

	// settle timer gives software a ready indication after reference turn-on
	always_ff @(posedge ref_clk) begin
		if (rst || !cfgRefOn) begin
			settleCount <= 16'h0000;
			refReady <= 1'b0;
		end else if (settleCount == 16'(REF_SETTLE_CYC)) begin
			refReady <= 1'b1; // R16
		end else begin
			settleCount <= settleCount + 16'h0001;
		end
	end
endmodule // adc_control_ref_power

// >>> adc_control_ref_power_monitor.sv
`timescale 1ns/1ps
module adc_control_ref_power_monitor (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        startConv,
	input wire logic        convEnableGate,
	input wire logic [7:0]  analogPinEnable,
	input wire logic        coreEnable,
	input wire logic        oscEnable,
	input wire logic        sampleActive,
	input wire logic        busy,
	input wire logic [11:0] muxConnect,
	input wire logic [11:0] muxGroundNode,
	input wire logic [7:0]  pinInputDisable,
	input wire logic [7:0]  pinOutputDisable,
	input wire logic        resultValid,
	input wire logic [9:0]  conversionResult,
	input wire logic        bandgapEnable,
	input wire logic        refBufferEnable,
	input wire logic        refBufferExternal
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// a start request that the gate lets through
	sequence s_take;
		startConv && convEnableGate && !busy;
	endsequence
	// result holds while its strobe drops after one cycle
	sequence s_pulse;
		##1 ($stable(conversionResult) && !resultValid);
	endsequence
	AST_GATE_START: assert property ($rose(busy) |-> $past(startConv, 2) && $past(convEnableGate, 2))
		else $error("busy rose without a gated start");
	AST_CORE_IDLE: assert property (coreEnable |-> busy || $past(busy))
		else $error("core enabled while idle");
	AST_OSC_IDLE: assert property (oscEnable |-> busy || $past(busy))
		else $error("oscillator enabled while idle");
	AST_MUX_ONE: assert property ($onehot0(muxConnect))
		else $error("more than one channel connected");
	AST_BBM: assert property (muxConnect != 0 && $past(muxConnect) != 0 |-> $stable(muxConnect))
		else $error("channel changed without a break");
	AST_GROUND: assert property (muxGroundNode == ~muxConnect)
		else $error("switch node grounding wrong");
	AST_PIN: assert property (pinInputDisable == $past(analogPinEnable) && pinOutputDisable == pinInputDisable)
		else $error("pin buffer disables wrong");
	AST_PULSE: assert property (resultValid |-> s_pulse)
		else $error("result strobe not a single cycle");
	AST_BUF_IDLE: assert property (refBufferEnable && !busy && !$past(busy) |-> bandgapEnable || refBufferExternal)
		else $error("idle buffer on without a reference");
	AST_MUX_SAMPLE: assert property (muxConnect != 0 |-> sampleActive || $past(sampleActive))
		else $error("channel connected outside sampling");
	cover property (s_take ##1 busy);
endmodule // adc_control_ref_power_monitor

bind adc_control_ref_power adc_control_ref_power_monitor adc_control_ref_power_monitor_i (
	.ref_clk(ref_clk), .rst(rst), .startConv(startConv), .convEnableGate(convEnableGate),
	.analogPinEnable(analogPinEnable), .coreEnable(coreEnable), .oscEnable(oscEnable),
	.sampleActive(sampleActive), .busy(busy), .muxConnect(muxConnect),
	.muxGroundNode(muxGroundNode), .pinInputDisable(pinInputDisable),
	.pinOutputDisable(pinOutputDisable), .resultValid(resultValid),
	.conversionResult(conversionResult), .bandgapEnable(bandgapEnable),
	.refBufferEnable(refBufferEnable), .refBufferExternal(refBufferExternal));

// >>> adc_analog_model.sv
`timescale 1ns/1ps
module adc_analog_model (
	input  wire logic              ref_clk,
	input  wire logic [11:0][10:0] vin,
	input  wire logic [11:0]       muxConnect,
	input  wire logic [9:0]        dacCode,
	output logic                   compHigh
);
	logic [10:0] held = 11'h000;    // charge left on the sampling cap
	// the cap follows whichever channel is connected
	always @(posedge ref_clk) begin
		for (int i = 0; i < 12; i++) begin
			if (muxConnect[i]) begin
				held <= vin[i];
			end
		end
	end
	// comparator: high while the held input is at or above the trial code
	assign compHigh = held >= {1'b0, dacCode};
endmodule // adc_analog_model

// >>> test_adc_control_ref_power.sv
`timescale 1ns/1ps
module test_adc_control_ref_power;
	import adc_ctl_pkg::*;
	logic ref_clk = 0, rst = 1, cfgWrite = 0, convEnableGate = 0, startConv = 0;
	logic corePowerOn = 0, twosComplement = 0, tickOn = 1;
	logic refGeneratorOn = 0, refLevelSelect = 0, refPinOutput = 0, refSelectBit0 = 0;
	logic refSelectBit1 = 0, refBufferBurst = 0, refBufferSlowRate = 0;
	logic subsystemTick = 0, mainTick = 0, auxTick = 0, oscTick = 0, compHigh;
	clk_src_t clkSourceSelect = SRC_SUBSYSTEM;
	logic [2:0] clkDivideSelect = 3'h0;
	logic [1:0] sampleHoldTimeSelect = 2'h0;
	logic [3:0] channelSelect = 4'h0;
	logic [7:0] analogPinEnable = 8'h00, pinInputDisable, pinOutputDisable;
	logic [9:0] dacCode, conversionResult;
	logic [11:0] muxConnect, muxGroundNode;
	logic [11:0][10:0] vin = '0;
	logic coreEnable, sampleActive, oscEnable, bandgapEnable, refBufferEnable, refLevel2v5;
	logic refBufferExternal, refBufferLowPower, refDriveOut, refReady, resultValid;
	logic resultInvalid, busy;
	int mismatches = 0, total_checks = 0, tc = 0;
	logic [31:0] seed = 32'h907fd571;
	adc_control_ref_power #(.STALL_LIMIT(64)) adc_control_ref_power_i (
		.ref_clk(ref_clk), .rst(rst), .cfgWrite(cfgWrite), .convEnableGate(convEnableGate),
		.startConv(startConv), .corePowerOn(corePowerOn), .clkSourceSelect(clkSourceSelect),
		.clkDivideSelect(clkDivideSelect), .sampleHoldTimeSelect(sampleHoldTimeSelect),
		.channelSelect(channelSelect), .twosComplement(twosComplement),
		.refGeneratorOn(refGeneratorOn), .refLevelSelect(refLevelSelect),
		.refPinOutput(refPinOutput), .refSelectBit0(refSelectBit0), .refSelectBit1(refSelectBit1),
		.refBufferBurst(refBufferBurst), .refBufferSlowRate(refBufferSlowRate),
		.analogPinEnable(analogPinEnable), .subsystemTick(subsystemTick), .mainTick(mainTick),
		.auxTick(auxTick), .oscTick(oscTick), .compHigh(compHigh), .dacCode(dacCode),
		.coreEnable(coreEnable), .sampleActive(sampleActive), .oscEnable(oscEnable),
		.muxConnect(muxConnect), .muxGroundNode(muxGroundNode),
		.pinInputDisable(pinInputDisable), .pinOutputDisable(pinOutputDisable),
		.bandgapEnable(bandgapEnable), .refBufferEnable(refBufferEnable),
		.refLevel2v5(refLevel2v5), .refBufferExternal(refBufferExternal),
		.refBufferLowPower(refBufferLowPower), .refDriveOut(refDriveOut), .refReady(refReady),
		.conversionResult(conversionResult), .resultValid(resultValid),
		.resultInvalid(resultInvalid), .busy(busy));
	adc_analog_model adc_analog_model_i (.ref_clk(ref_clk), .vin(vin),
		.muxConnect(muxConnect), .dacCode(dacCode), .compHigh(compHigh));
	always #12.5 ref_clk = ~ref_clk;
	// source clocks: periods of 1, 2, 3 and 4 cycles, all stoppable
	always @(negedge ref_clk) begin
		tc <= tc + 1;
		subsystemTick <= tickOn;
		mainTick <= tickOn && tc % 2 == 0;
		auxTick <= tickOn && tc % 3 == 0;
		oscTick <= tickOn && tc % 4 == 0;
	end
	// counts a comparison, reports a difference
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// straight or flipped-msb code of a saturated input
	function automatic logic [15:0] expRes(input logic [10:0] v, input logic tw);
		logic [9:0] r;
		r = v > 11'h3FF ? FULL_SCALE : v[9:0];
		return {6'h00, r ^ (tw ? SIGN_FLIP : 10'h000)};
	endfunction
	// rf: power, on, level, out, sel0, sel1, burst, slow
	function automatic logic [15:0] expRef(input logic [7:0] rf);
		logic ext;
		ext = rf[3] & rf[2];
		return {11'h000, rf[6], rf[5], ext, rf[0], (rf[6] | ext) & rf[4] & !rf[1]};
	endfunction
	// one configuration write
	task automatic cfg(input logic [3:0] ch, input logic [7:0] sel, input logic [7:0] rf);
		{channelSelect, clkDivideSelect, sampleHoldTimeSelect, twosComplement} = {ch, sel[5:0]};
		clkSourceSelect = clk_src_t'(sel[7:6]);
		{corePowerOn, refGeneratorOn, refLevelSelect, refPinOutput} = rf[7:4];
		{refSelectBit0, refSelectBit1, refBufferBurst, refBufferSlowRate} = rf[3:0];
		cfgWrite = 1;
		@(negedge ref_clk);
		cfgWrite = 0;
		repeat (2) @(negedge ref_clk);
	endtask
	// pulse start; expect busy to stay low
	task automatic noStart;
		startConv = 1;
		@(negedge ref_clk);
		startConv = 0;
		@(negedge ref_clk);
		chk(busy, 16'h0000);
	endtask
	// gated conversion on the configured channel
	task automatic convert;
		int n = 0, sa = 0, span, hold;
		logic sc = 0, so = 0;
		span = (int'(clkSourceSelect) + 1) * (clkDivideSelect + 1);
		hold = sampleHoldTimeSelect == 2'h3 ? 64 : 4 << sampleHoldTimeSelect;
		convEnableGate = 1;
		startConv = 1;
		@(negedge ref_clk);
		startConv = 0;
		while (resultValid !== 1'b1 && n < 4000) begin
			@(negedge ref_clk);
			n++;
			sa += sampleActive === 1'b1;
			sc |= coreEnable === 1'b1;
			so |= oscEnable === 1'b1;
		end
		convEnableGate = 0;
		chk(conversionResult, expRes(vin[channelSelect], twosComplement));
		chk({resultValid, sc, so, resultInvalid}, {2'b11, clkSourceSelect == SRC_OSC, 1'b0});
		chk(16'(sa >= (hold - 1) * span && sa <= (hold + 1) * span), 16'h0001);
		$display("test convert ch %0d done", channelSelect);
	endtask
	initial begin
		#(25 * 80000);
		mismatches++;
		report_and_stop;
	end
	initial begin
		repeat (2) @(negedge ref_clk);
		rst = 0;
		chk({busy, muxGroundNode}, 16'h0FFF);
		convEnableGate = 1;
		cfg(4'h0, 8'h00, 8'hFF);
		chk(bandgapEnable, 16'h0000);
		convEnableGate = 0;
		for (int i = 0; i < 10; i++) begin
			logic [7:0] rf;
			rf = i == 0 ? 8'hFF : i == 1 ? 8'hDA : 8'($random(seed));
			cfg(4'h0, 8'h00, rf);
			chk(expRef(rf), {bandgapEnable, refLevel2v5, refBufferExternal, refBufferLowPower,
				refBufferEnable});
			chk(refDriveOut, 16'(rf[6] & rf[4]));
		end
		$display("test reference done");
		cfg(4'h0, 8'h00, 8'h40);
		for (int n = 0; n < 1300 && refReady !== 1'b1; n++) @(negedge ref_clk);
		chk(refReady, 16'h0001);
		cfg(4'h0, 8'h00, 8'h80);
		noStart;
		cfg(4'h0, 8'h00, 8'h00);
		convEnableGate = 1;
		cfg(4'h0, 8'h00, 8'h80);
		noStart;
		convEnableGate = 0;
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j < 12; j++) vin[j] = 11'($random(seed));
			vin[0] = i == 0 ? 11'h000 : 11'h7FF;
			cfg(i < 2 ? 4'h0 : 4'($unsigned($random(seed)) % 12), 8'($random(seed)), 8'hC0);
			convert;
		end
		cfg(4'h3, 8'hC3, 8'h80);
		convEnableGate = 1;
		startConv = 1;
		@(negedge ref_clk);
		startConv = 0;
		repeat (20) @(negedge ref_clk);
		tickOn = 0;
		for (int n = 0; n < 120 && resultInvalid !== 1'b1; n++) @(negedge ref_clk);
		@(negedge ref_clk);
		chk({resultInvalid, resultValid, busy}, 16'h0004);
		tickOn = 1;
		convEnableGate = 0;
		cfg(4'h3, 8'h00, 8'h80);
		convert;
		repeat (4) begin
			analogPinEnable = 8'($random(seed));
			@(negedge ref_clk);
			chk({pinInputDisable, pinOutputDisable}, {2{analogPinEnable}});
		end
		$display("test stall and pins done");
		report_and_stop;
	end
endmodule // test_adc_control_ref_power
